// File: logic/uft_defs.svh
/*
  Offsets, field positions, reset values and rates for the frame-timing counters.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef UFT_DEFS_SVH
`define UFT_DEFS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define UFT_ADDR_W 8
`define UFT_OFS_TIME_LEFT 8'h38
`define UFT_OFS_COUNT 8'h3C

// ----------------------------------------
// fields
// ----------------------------------------
`define UFT_LEFT_W 14
`define UFT_LEFT_MSB 13
`define UFT_TOGGLE_BIT 31
`define UFT_COUNT_W 16
`define UFT_COUNT_MSB 15
`define UFT_TIME_LEFT_RST 32'h0000_0000
`define UFT_COUNT_RST 32'h0000_0000
`define UFT_LEFT_RST 14'h0000
`define UFT_COUNT_FIELD_RST 16'h0000
`define UFT_LEFT_ZERO 14'h0000
`define UFT_LEFT_ONE 14'h0001
`define UFT_COUNT_ONE 16'h0001
`define UFT_INTERVAL_NOMINAL 14'h2EDF

// ----------------------------------------
// timing: controller clock against full-speed bit rate
// ----------------------------------------
`define UFT_CLK_KHZ 40000
`define UFT_BIT_KHZ 12000

`endif

// File: logic/uft_pkg.sv
/*
  Types shared by the frame-timing counters.
  Assumes uft_defs.svh supplies all numeric constants.
*/
package uft_pkg;

  // frame boundary sequencer, one-hot
  typedef enum logic [3:0] {
    UFT_IDLE = 4'b0001,
    UFT_SOF = 4'b0010,
    UFT_HCCA = 4'b0100,
    UFT_FLAG = 4'b1000
  } uft_state_e;

endpackage

// File: logic/uft_tick_if.sv
/*
  Carrier between the bit-time tick generator and the frame timer.
  Assumes one clock domain; all signals are sampled on mclk.
*/
`timescale 1ns/100ps

interface uft_tick_if;
  logic ce;
  logic tick;

  modport gen (
    input ce,
    output tick
  );
  modport use_side (
    output ce,
    input tick
  );
endinterface // uft_tick_if

// File: logic/uft_tick_gen.sv
/*
  Bit-time tick generator: fractional divider from the controller clock.
  Assumes mclk is the controller clock and rates come from uft_defs.svh.
*/
`timescale 1ns/100ps
`include "uft_defs.svh"

module uft_tick_gen #(
  parameter int CLK_KHZ = `UFT_CLK_KHZ,
  parameter int BIT_KHZ = `UFT_BIT_KHZ
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // tick carrier
  uft_tick_if.gen tk
);

  // ----------------------------------------
  // phase accumulator
  // ----------------------------------------
  // rate ratio is not an integer, so ticks jitter by one clock but never drift
  localparam int ACC_W = $clog2(CLK_KHZ + BIT_KHZ) + 1;
  localparam logic [ACC_W-1:0] STEP = ACC_W'(BIT_KHZ);
  localparam logic [ACC_W-1:0] WRAP = ACC_W'(CLK_KHZ);

  logic [ACC_W-1:0] acc;
  logic tick;
  wire [ACC_W-1:0] sum = acc + STEP;
  wire over = (sum >= WRAP);
  wire [ACC_W-1:0] next_acc = over ? (sum - WRAP) : sum;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      tick <= 1'b0;
    end else if (tk.ce) begin
      acc <= next_acc;
      tick <= over;
    end
  end

  assign tk.tick = tick;

endmodule // uft_tick_gen

// File: logic/uft_frame_timer.sv
/*
  Frame-timing counters: frame time left, frame count, frame boundary sequence.
  Assumes the interval register, SOF sender, shared-area writer and interrupt
  status register sit outside and answer the handshakes below.
*/
`timescale 1ns/100ps
`include "uft_defs.svh"

module uft_frame_timer #(
  parameter int CLK_KHZ = `UFT_CLK_KHZ,
  parameter int BIT_KHZ = `UFT_BIT_KHZ
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // controller state and interval register fields
  input wire logic running_state,
  input wire logic [`UFT_LEFT_MSB:0] frame_interval_value,
  input wire logic interval_toggle,
  // register port
  input wire logic [`UFT_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // SOF sender handshake
  output logic sof_req,
  input wire logic sof_done,
  // shared-area write handshake
  output logic hcca_wr_req,
  output logic [`UFT_COUNT_MSB:0] hcca_wr_data,
  input wire logic hcca_wr_ack,
  // descriptor fetch permission and status flag
  output logic ed_fetch_ok,
  output logic frame_start_flag
);

  // ----------------------------------------
  // bit-time ticks
  // ----------------------------------------
  // ce freezes the divider too, so tick spacing survives a pause
  uft_tick_if tk ();
  assign tk.ce = ce;

  uft_tick_gen #(
    .CLK_KHZ(CLK_KHZ),
    .BIT_KHZ(BIT_KHZ)
  ) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .tk(tk)
  );

  // ----------------------------------------
  // state and decode
  // ----------------------------------------
  logic [`UFT_LEFT_MSB:0] bit_times_left;
  logic remaining_toggle;
  logic [`UFT_COUNT_MSB:0] frame_count_field;
  logic [`UFT_LEFT_MSB:0] active_interval;
  logic active_toggle;
  logic run_q;
  uft_pkg::uft_state_e state;

  wire sel_left = (reg_addr == `UFT_OFS_TIME_LEFT);
  wire sel_count = (reg_addr == `UFT_OFS_COUNT);
  // reserved bits are dropped on write, so stray ones cannot stick
  wire wr_left = reg_wr && sel_left;
  wire wr_count = reg_wr && sel_count;
  wire run_entry = running_state && !run_q;
  wire at_zero = (bit_times_left == `UFT_LEFT_ZERO);
  wire dec_en = running_state && tk.tick && !at_zero;
  wire reload = running_state && tk.tick && at_zero;
  wire frame_edge = reload || run_entry;
  wire [`UFT_COUNT_MSB:0] count_inc = frame_count_field + `UFT_COUNT_ONE;

  // ----------------------------------------
  // frame time left and toggle
  // ----------------------------------------
  // entry takes the interval as it stands now, reloads take the registered copy; a rewrite
  // during a frame is in force from the next reload on, and the copy used
  // for reloads lags the input by one clock only
  wire [`UFT_LEFT_MSB:0] next_left =
    run_entry ? frame_interval_value :
    reload ? active_interval :
    dec_en ? (bit_times_left - `UFT_LEFT_ONE) :
    wr_left ? reg_wdata[`UFT_LEFT_MSB:0] :
    bit_times_left;

  wire next_toggle =
    reload ? active_toggle :
    wr_left ? reg_wdata[`UFT_TOGGLE_BIT] :
    remaining_toggle;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_times_left <= `UFT_LEFT_RST;
      remaining_toggle <= 1'b0;
      run_q <= 1'b0;
    end else if (ce) begin
      bit_times_left <= next_left;
      remaining_toggle <= next_toggle;
      run_q <= running_state;
    end
  end

  // ----------------------------------------
  // reload source
  // ----------------------------------------
  // value and toggle move together on a reload, but entry loads only the value,
  // so until the first reload the toggle can announce an interval other than the one loaded
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active_interval <= `UFT_INTERVAL_NOMINAL;
      active_toggle <= 1'b0;
    end else if (ce) begin
      active_interval <= frame_interval_value;
      active_toggle <= interval_toggle;
    end
  end

  // ----------------------------------------
  // frame count
  // ----------------------------------------
  // a software write in a boundary cycle is lost; the increment wins
  wire [`UFT_COUNT_MSB:0] next_count =
    frame_edge ? count_inc :
    wr_count ? reg_wdata[`UFT_COUNT_MSB:0] :
    frame_count_field;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_count_field <= `UFT_COUNT_FIELD_RST;
    end else if (ce) begin
      frame_count_field <= next_count;
    end
  end

  // ----------------------------------------
  // frame boundary sequence
  // ----------------------------------------
  // a boundary during an unfinished sequence restarts it; the newest count wins
  uft_pkg::uft_state_e next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      uft_pkg::UFT_IDLE: begin
        if (frame_edge) next_state = uft_pkg::UFT_SOF;
      end
      uft_pkg::UFT_SOF: begin
        if (sof_done) next_state = uft_pkg::UFT_HCCA;
      end
      uft_pkg::UFT_HCCA: begin
        if (hcca_wr_ack) next_state = uft_pkg::UFT_FLAG;
      end
      uft_pkg::UFT_FLAG: begin
        next_state = uft_pkg::UFT_IDLE;
      end
      default: next_state = uft_pkg::UFT_IDLE;
    endcase
    if (frame_edge) next_state = uft_pkg::UFT_SOF;
  end

  wire next_sof_req = (next_state == uft_pkg::UFT_SOF);
  wire next_hcca_req = (next_state == uft_pkg::UFT_HCCA);
  wire next_flag = (next_state == uft_pkg::UFT_FLAG);
  // first descriptor only after the count is in the shared area
  wire next_fetch_ok = running_state && (next_state == uft_pkg::UFT_IDLE ||
                                         next_state == uft_pkg::UFT_FLAG);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= uft_pkg::UFT_IDLE;
      sof_req <= 1'b0;
      hcca_wr_req <= 1'b0;
      hcca_wr_data <= '0;
      frame_start_flag <= 1'b0;
      ed_fetch_ok <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      sof_req <= next_sof_req;
      hcca_wr_req <= next_hcca_req;
      frame_start_flag <= next_flag;
      ed_fetch_ok <= next_fetch_ok;
      if (frame_edge) begin
        hcca_wr_data <= count_inc;
      end
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  // reserved positions read back as zero whatever was written
  wire [31:0] left_word = {remaining_toggle, 17'h00000, bit_times_left};
  wire [31:0] count_word = {16'h0000, frame_count_field};
  wire [31:0] next_rdata = sel_left ? left_word :
                           sel_count ? count_word : 32'h0000_0000;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce && reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // uft_frame_timer

// File: tb/uft_frame_timer_chk.sv
/*
  Checker for the frame-timing counters, bound to the top module.
  Assumes one clock domain, mclk, and asynchronous active-low rst_n.
*/
`timescale 1ns/100ps

module uft_frame_timer_chk (
  // clock, reset, enable and controller state
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic running_state,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // boundary handshakes
  input wire logic sof_req,
  input wire logic sof_done,
  input wire logic hcca_wr_req,
  input wire logic [15:0] hcca_wr_data,
  input wire logic hcca_wr_ack,
  input wire logic ed_fetch_ok,
  input wire logic frame_start_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_sof_sent;
    sof_req && sof_done;
  endsequence
  sequence s_wr_acked;
    hcca_wr_req && hcca_wr_ack;
  endsequence
  a_sof_then_wr: assert property (s_sof_sent |=> !sof_req && hcca_wr_req)
    else $error("shared-area write did not follow the SOF");
  a_flag_after_wr: assert property (s_wr_acked |=> frame_start_flag)
    else $error("start flag missing after the write");
  a_flag_one_cyc: assert property (frame_start_flag |=> !frame_start_flag)
    else $error("start flag longer than one cycle");
  a_flag_cause: assert property ($rose(frame_start_flag) |-> $past(hcca_wr_ack))
    else $error("start flag without a finished write");
  a_wr_data_hold: assert property (hcca_wr_req && !hcca_wr_ack |=> $stable(hcca_wr_data))
    else $error("shared-area data moved during the request");
  a_entry_sof: assert property ($rose(running_state) && ce |=> sof_req)
    else $error("no frame start on entry to running");
  a_fetch_after: assert property (sof_req || hcca_wr_req |-> !ed_fetch_ok)
    else $error("descriptor fetch allowed before the count write");
  a_rsvd_zero: assert property (ce && reg_rd && reg_addr == 8'h3C |=> reg_rdata[31:16] == '0)
    else $error("frame count word has bits above 15");
endmodule // uft_frame_timer_chk

bind uft_frame_timer uft_frame_timer_chk u_chk (.mclk, .rst_n, .ce, .running_state, .reg_addr,
  .reg_rd, .reg_rdata, .sof_req, .sof_done, .hcca_wr_req, .hcca_wr_data, .hcca_wr_ack,
  .ed_fetch_ok, .frame_start_flag);

// File: tb/tb_uft_frame_timer.sv
/*
  Self-checking bench for the frame-timing counters.
  Assumes equal rates make the divider tick every enabled cycle.
*/
`timescale 1ns/100ps

module tb_uft_frame_timer;
  logic mclk = 0, rst_n = 0, ce = 0, running_state = 0, interval_toggle = 0;
  logic reg_wr = 0, reg_rd = 0, sof_done = 0, hcca_wr_ack = 0;
  logic [13:0] frame_interval_value = 14'h0006;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = '0, reg_rdata, rd;
  logic sof_req, hcca_wr_req, ed_fetch_ok, frame_start_flag;
  logic [15:0] hcca_wr_data;
  int err_total = 0, n_checks = 0;
  logic [31:0] held;
  // which output wait_for watches
  localparam int W_WR = 0, W_FLAG = 1, W_SOF = 2;

  uft_frame_timer #(.CLK_KHZ(40000), .BIT_KHZ(40000)) DUT (.mclk, .rst_n, .ce, .running_state,
    .frame_interval_value, .interval_toggle, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .sof_req, .sof_done, .hcca_wr_req, .hcca_wr_data, .hcca_wr_ack,
    .ed_fetch_ok, .frame_start_flag);

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  // sender and shared-area writer answer one cycle late
  always @(posedge mclk) begin
    sof_done <= sof_req & ~sof_done;
    hcca_wr_ack <= hcca_wr_req & ~hcca_wr_ack;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(posedge mclk);
    rd = reg_rdata;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  // bounded wait; test frames are only a few clocks long
  task automatic wait_for(input int which);
    int i;
    logic s;
    s = 1'h0;
    for (i = 0; i < 100 && s !== 1'h1; i++) begin
      @(posedge mclk);
      s = (which == W_WR) ? hcca_wr_req : (which == W_FLAG) ? frame_start_flag : sof_req;
    end
    chk("wait", {31'h0, s}, 32'h1);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    // all tests together take under a hundred clocks
    repeat (3000) @(posedge mclk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    ce <= 1'h1;
    rd_reg(8'h38); chk("time left", rd, '0);
    rd_reg(8'h3C); chk("count", rd, '0);
    rd_reg(8'h44); chk("unmapped", rd, '0);
    $display("test reset done");
    interval_toggle <= 1'h1;
    running_state <= 1'h1;
    wait_for(W_WR);
    chk("hcca data", hcca_wr_data, 32'h1);
    wait_for(W_FLAG);
    chk("fetch ok", ed_fetch_ok, 32'h1);
    wait_for(W_SOF);
    wait_for(W_FLAG);
    running_state <= 1'h0;
    rd_reg(8'h3C); chk("count", rd, 32'h2);
    rd_reg(8'h38); chk("toggle", rd[31], 32'h1);
    chk("rsvd", rd[30:14], '0);
    held = rd;
    rd_reg(8'h38); chk("held", rd, held);
    $display("test frames done");
    wr_reg(8'h3C, 32'h0000FFFF);
    wr_reg(8'h38, 32'h80000005);
    rd_reg(8'h38); chk("left wr", rd, 32'h80000005);
    rd_reg(8'h3C); chk("count wr", rd, 32'hFFFF);
    // running for one clock only: entry load, then the counter holds
    running_state <= 1'h1;
    @(posedge mclk);
    running_state <= 1'h0;
    wait_for(W_WR);
    chk("wrap", hcca_wr_data, '0);
    rd_reg(8'h38); chk("entry load", rd, 32'h80000006);
    rd_reg(8'h3C); chk("wrapped", rd, '0);
    $display("test wrap done");
    // new interval with flipped toggle; entry loads 5, then seven ticks
    // give 4 3 2 1 0, a reload to 5, and 4
    frame_interval_value <= 14'h0005;
    interval_toggle <= 1'h0;
    running_state <= 1'h1;
    repeat (8) @(posedge mclk);
    running_state <= 1'h0;
    rd_reg(8'h38); chk("reload", rd, 32'h00000004);
    rd_reg(8'h3C); chk("reloads", rd, 32'h2);
    $display("test reload done");
    tally_and_finish();
  end
endmodule // tb_uft_frame_timer
